// *** core/cst_pkg.sv ***
// Purpose: shared constants and carriers for the clock-sync loop tuning registers
// Assumes: byte-wide register ports, one clock domain
// Notes: offsets are byte addresses within the controller register space
package cst_pkg;

  localparam int ADDR_W = 12;

  // register byte offsets
  localparam logic [11:0] OFS_TIME_DIFF_B0 = 12'h92c;
  localparam logic [11:0] OFS_TIME_DIFF_B1 = 12'h92d;
  localparam logic [11:0] OFS_TIME_DIFF_B2 = 12'h92e;
  localparam logic [11:0] OFS_TIME_DIFF_B3 = 12'h92f;
  localparam logic [11:0] OFS_BANDWIDTH_LO = 12'h930;
  localparam logic [11:0] OFS_BANDWIDTH_HI = 12'h931;
  localparam logic [11:0] OFS_SPEED_DEV_LO = 12'h932;
  localparam logic [11:0] OFS_SPEED_DEV_HI = 12'h933;
  localparam logic [11:0] OFS_TDIFF_DEPTH = 12'h934;
  localparam logic [11:0] OFS_SPEED_DEPTH = 12'h935;
  localparam logic [11:0] OFS_UNIT_OWNER = 12'h980;

  // field positions of the cyclic unit ownership register and of the time-difference sign
  localparam int BIT_SYNC_OUT = 0;
  localparam int BIT_LATCH0 = 4;
  localparam int BIT_LATCH1 = 5;
  localparam int BIT_TDIFF_SIGN = 31;

  // field widths
  localparam int BW_W = 15;
  localparam int DEPTH_W = 4;
  localparam int DEV_W = 16;
  localparam int TDIFF_MAG_W = 31;

  // reset values
  localparam logic [14:0] RST_BANDWIDTH = 15'h1000;
  localparam logic [15:0] RST_SPEED_DEV = 16'h0000;
  localparam logic [3:0] RST_TDIFF_DEPTH = 4'h4;
  localparam logic [3:0] RST_SPEED_DEPTH = 4'hc;
  localparam logic [31:0] RST_TIME_DIFF = 32'h0000_0000;

  // lowest bandwidth setting the writer may program; writes below it are accepted, nothing checks it
  localparam logic [14:0] MIN_BANDWIDTH = 15'h007f;

  // one register access port, byte wide
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wrData;
    logic wrEn;
    logic rdEn;
  } cst_acc_t;

  // read answer of one port
  typedef struct packed {
    logic [7:0] rdData;
    logic rdValid;
  } cst_rsp_t;

  // results delivered by the loop arithmetic
  typedef struct packed {
    logic timeDiffValid;
    logic [30:0] timeDiffMag;
    logic localSmaller;
    logic speedDevValid;
    logic [15:0] speedDev;
  } cst_loop_t;

endpackage

// *** core/cst_tuning_regs.sv ***
// Purpose: tuning and ownership registers of the distributed-clock time loop
// Assumes: network and host ports are byte wide and synchronous to clk
// Notes: read data appears one cycle after rdEn; loop math lives outside
`timescale 1ns/1ps

// Function
// - hold a 15-bit loop bandwidth setting; larger means smoother correction
// - any bandwidth write clears averaged time difference and speed deviation
// - speed deviation is 16-bit read-only, neither port writes it
// - 4-bit time-difference filter depth, reset value four
// - writing time-difference filter depth clears averaged time difference
// - 4-bit speed filter depth for clock period deviation averaging
// - writing speed filter depth resets the internal speed averaging filter
// - tuning registers writable by network; host only when configured
// - ownership bit 0 gives sync-output unit to host; network-only write
// - ownership bit 4 gives first latch unit to host
// - first latch bit reads one while time loop belongs to host
// - ownership bit 5 gives second latch unit to host
// - time difference: magnitude in 30:0, bit 31 set if local smaller
module cst_tuning_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // configuration levels
  input wire logic hostWriteAllowed,
  input wire logic timeLoopHostOwned,
  // network side port
  input wire cst_pkg::cst_acc_t netAcc,
  output cst_pkg::cst_rsp_t netRsp,
  // host side interface
  input wire cst_pkg::cst_acc_t hostAcc,
  output cst_pkg::cst_rsp_t hostRsp,
  // results from the loop arithmetic
  input wire cst_pkg::cst_loop_t loopIn,
  // settings to the loop arithmetic
  output logic [14:0] bandwidthSetting,
  output logic [3:0] timeDiffDepth,
  output logic [3:0] speedDepth,
  output logic timeDiffClear,
  output logic speedDevClear,
  output logic speedFilterReset,
  // unit ownership, high means host controlled
  output logic syncOutHostOwned,
  output logic latch0HostOwned,
  output logic latch1HostOwned
);

  typedef struct packed {
    logic [14:0] bandwidth;
    logic [15:0] speedDev;
    logic [31:0] timeDiff;
    logic [3:0] tdiffDepth;
    logic [3:0] speedDepth;
    logic syncOwner;
    logic latch0Owner;
    logic latch1Owner;
    logic tdiffClr;
    logic devClr;
    logic speedFltRst;
    cst_pkg::cst_rsp_t netRsp;
    cst_pkg::cst_rsp_t hostRsp;
  } cst_state_t;

  cst_state_t state_q;
  cst_state_t state_d;

  // read mux shared by both ports
  function automatic logic [7:0] readByte(input cst_state_t s, input logic [11:0] a,
                                          input logic loopHost);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      cst_pkg::OFS_TIME_DIFF_B0: r = s.timeDiff[7:0];
      cst_pkg::OFS_TIME_DIFF_B1: r = s.timeDiff[15:8];
      cst_pkg::OFS_TIME_DIFF_B2: r = s.timeDiff[23:16];
      cst_pkg::OFS_TIME_DIFF_B3: r = s.timeDiff[31:24];
      cst_pkg::OFS_BANDWIDTH_LO: r = s.bandwidth[7:0];
      cst_pkg::OFS_BANDWIDTH_HI: r = {1'b0, s.bandwidth[14:8]};
      cst_pkg::OFS_SPEED_DEV_LO: r = s.speedDev[7:0];
      cst_pkg::OFS_SPEED_DEV_HI: r = s.speedDev[15:8];
      cst_pkg::OFS_TDIFF_DEPTH: r = {4'h0, s.tdiffDepth};
      cst_pkg::OFS_SPEED_DEPTH: r = {4'h0, s.speedDepth};
      cst_pkg::OFS_UNIT_OWNER: begin
        r[cst_pkg::BIT_SYNC_OUT] = s.syncOwner;
        r[cst_pkg::BIT_LATCH0] = s.latch0Owner | loopHost;
        r[cst_pkg::BIT_LATCH1] = s.latch1Owner;
      end
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // byte write into the tuning registers; flags report side effects
  function automatic cst_state_t writeTuning(input cst_state_t s, input logic [11:0] a,
                                             input logic [7:0] w);
    cst_state_t n;
    n = s;
    case (a)
      cst_pkg::OFS_BANDWIDTH_LO: begin
        n.bandwidth[7:0] = w;
        n.tdiffClr = 1'b1;
        n.devClr = 1'b1;
      end
      cst_pkg::OFS_BANDWIDTH_HI: begin
        n.bandwidth[14:8] = w[6:0];
        n.tdiffClr = 1'b1;
        n.devClr = 1'b1;
      end
      cst_pkg::OFS_TDIFF_DEPTH: begin
        n.tdiffDepth = w[3:0];
        n.tdiffClr = 1'b1;
      end
      cst_pkg::OFS_SPEED_DEPTH: begin
        n.speedDepth = w[3:0];
        n.speedFltRst = 1'b1;
      end
      default: n = s;
    endcase
    return n;
  endfunction

  always_comb begin
    state_d = state_q;
    state_d.tdiffClr = 1'b0;
    state_d.devClr = 1'b0;
    state_d.speedFltRst = 1'b0;

    // host first so a same-cycle network write to the same byte wins
    if (hostAcc.wrEn && hostWriteAllowed) begin
      state_d = writeTuning(state_d, hostAcc.addr, hostAcc.wrData);
    end
    if (netAcc.wrEn) begin
      state_d = writeTuning(state_d, netAcc.addr, netAcc.wrData);
      // ownership is never taken from the host side
      if (netAcc.addr == cst_pkg::OFS_UNIT_OWNER) begin
        state_d.syncOwner = netAcc.wrData[cst_pkg::BIT_SYNC_OUT];
        state_d.latch0Owner = netAcc.wrData[cst_pkg::BIT_LATCH0];
        state_d.latch1Owner = netAcc.wrData[cst_pkg::BIT_LATCH1];
      end
    end

    // clears first; a fresh loop result in the same cycle wins
    if (state_d.tdiffClr) begin
      state_d.timeDiff = cst_pkg::RST_TIME_DIFF;
    end
    if (state_d.devClr) begin
      state_d.speedDev = cst_pkg::RST_SPEED_DEV;
    end
    if (loopIn.timeDiffValid) begin
      state_d.timeDiff = {loopIn.localSmaller, loopIn.timeDiffMag};
    end
    // deviation is loaded only by the loop, no port reaches it
    if (loopIn.speedDevValid) begin
      state_d.speedDev = loopIn.speedDev;
    end

    // reads see the value before this cycle's writes
    state_d.netRsp.rdValid = netAcc.rdEn;
    state_d.netRsp.rdData = netAcc.rdEn ?
        readByte(state_q, netAcc.addr, timeLoopHostOwned) : 8'h00;
    state_d.hostRsp.rdValid = hostAcc.rdEn;
    state_d.hostRsp.rdData = hostAcc.rdEn ?
        readByte(state_q, hostAcc.addr, timeLoopHostOwned) : 8'h00;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= '0;
      state_q.bandwidth <= cst_pkg::RST_BANDWIDTH;
      state_q.speedDev <= cst_pkg::RST_SPEED_DEV;
      state_q.timeDiff <= cst_pkg::RST_TIME_DIFF;
      state_q.tdiffDepth <= cst_pkg::RST_TDIFF_DEPTH;
      state_q.speedDepth <= cst_pkg::RST_SPEED_DEPTH;
    end else begin
      state_q <= state_d;
    end
  end

  assign netRsp = state_q.netRsp;
  assign hostRsp = state_q.hostRsp;
  assign bandwidthSetting = state_q.bandwidth;
  assign timeDiffDepth = state_q.tdiffDepth;
  assign speedDepth = state_q.speedDepth;
  assign timeDiffClear = state_q.tdiffClr;
  assign speedDevClear = state_q.devClr;
  assign speedFilterReset = state_q.speedFltRst;
  assign syncOutHostOwned = state_q.syncOwner;
  // forced view: a host-owned time loop drags the first latch along
  assign latch0HostOwned = state_q.latch0Owner | timeLoopHostOwned;
  assign latch1HostOwned = state_q.latch1Owner;

endmodule

// *** verification/cst_tuning_monitor.sv ***
// Purpose: port assertions for the tuning registers
// Assumes: one clock, async active-low reset
// Notes: sees top ports only, bound below
`timescale 1ns/1ps
module cst_tuning_monitor (
  // watched ports
  input wire logic clk,
  input wire logic rstn,
  input wire logic hostWriteAllowed,
  input wire logic timeLoopHostOwned,
  input wire cst_pkg::cst_acc_t netAcc,
  input wire logic [14:0] bandwidthSetting,
  input wire logic timeDiffClear,
  input wire logic speedDevClear,
  input wire logic speedFilterReset,
  input wire logic syncOutHostOwned,
  input wire logic latch0HostOwned
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_wr(a); netAcc.wrEn && netAcc.addr == a; endsequence
  a_bw_clears: assert property (s_wr(12'h930) or s_wr(12'h931)
    |=> timeDiffClear && speedDevClear) else $error("state kept");
  a_depth_clear: assert property (s_wr(12'h934) |=> timeDiffClear)
    else $error("diff kept");
  a_filter_reset: assert property (s_wr(12'h935) |=> speedFilterReset)
    else $error("filter kept");
  a_bw_low: assert property (s_wr(12'h930)
    |=> bandwidthSetting[7:0] == $past(netAcc.wrData)) else $error("low byte lost");
  a_bw_high: assert property (s_wr(12'h931)
    |=> bandwidthSetting[14:8] == $past(netAcc.wrData[6:0])) else $error("high byte lost");
  a_latch_forced: assert property (timeLoopHostOwned |-> latch0HostOwned)
    else $error("latch not forced");
  a_owner_net: assert property (!netAcc.wrEn |=> $stable(syncOutHostOwned))
    else $error("owner moved");
  a_host_refused: assert property (!netAcc.wrEn && !hostWriteAllowed
    |=> !timeDiffClear && !speedFilterReset) else $error("refused write acted");
endmodule
bind cst_tuning_regs cst_tuning_monitor i_mon (.*);

// *** verification/cst_loop_model.sv ***
// Purpose: stand-in for the loop arithmetic
// Assumes: fire is a one-cycle bench request
// Notes: stale values invert so late reads fail
`timescale 1ns/1ps
module cst_loop_model (
  // request and result
  input wire logic clk,
  input wire logic fire,
  output cst_pkg::cst_loop_t loop
);
  always_ff @(posedge clk) loop <= fire ? {1'h1, 31'h55, 2'h3, 16'h1234}
    : {1'h0, ~31'h55, 2'h0, ~16'h1234};
endmodule

// *** verification/clock_sync_loop_tuning_regs_tb.sv ***
// Purpose: directed checks of the tuning registers
// Assumes: reads answer one cycle after rdEn
// Notes: port 0 network side, port 1 host side
`timescale 1ns/1ps
module clock_sync_loop_tuning_regs_tb;
  logic clk = 1'h0, rstn = 1'h0, wrOk = 1'h0, loopHost = 1'h0, fire = 1'h0;
  logic [14:0] bw;
  logic [2:0] own;
  logic [3:0] tdd, spd;
  int err_total = 0, total_checks = 0;
  cst_pkg::cst_acc_t acc [2] = '{default: '0};
  cst_pkg::cst_rsp_t rsp [2];
  cst_pkg::cst_loop_t loop;
  initial forever #20 clk = ~clk;
  cst_loop_model i_loop (.clk(clk), .fire(fire), .loop(loop));
  cst_tuning_regs i_dut (.clk(clk), .rstn(rstn), .hostWriteAllowed(wrOk),
    .timeLoopHostOwned(loopHost), .netAcc(acc[0]), .netRsp(rsp[0]), .hostAcc(acc[1]),
    .hostRsp(rsp[1]), .loopIn(loop), .bandwidthSetting(bw), .timeDiffDepth(tdd),
    .speedDepth(spd), .timeDiffClear(), .speedDevClear(), .speedFilterReset(),
    .syncOutHostOwned(own[0]), .latch0HostOwned(own[1]), .latch1HostOwned(own[2]));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    err_total += int'(seen !== exp);
  endtask
  task bus(input int p, input logic [11:0] a, input logic [7:0] d, input logic w);
    @(posedge clk);
    acc[p] <= '{addr: a, wrData: d, wrEn: w, rdEn: !w};
    @(posedge clk);
    acc[p] <= '0;
    #1;
    if (!w) chk({rsp[p].rdValid, rsp[p].rdData}, {1'h1, d});
  endtask
  task t_fire;
    @(posedge clk);
    fire <= 1'h1;
    @(posedge clk);
    fire <= 1'h0;
  endtask
  task t_loop;
    bus(0, 12'h935, 8'h0c, 1'h0);
    chk(bw, 15'h1000);
    chk(tdd, 4'h4);
    t_fire();
    bus(1, 12'h92f, 8'h80, 1'h0);
    bus(1, 12'h92c, 8'h55, 1'h0);
    bus(0, 12'h934, 8'hff, 1'h1);
    chk(tdd, 4'hf);
    bus(0, 12'h934, 8'h0f, 1'h0);
    bus(0, 12'h92f, 8'h00, 1'h0);
    bus(0, 12'h933, 8'hff, 1'h1);
    bus(0, 12'h933, 8'h12, 1'h0);
    bus(0, 12'h935, 8'h03, 1'h1);
    chk(spd, 4'h3);
    t_fire();
    bus(0, 12'h92c, 8'h55, 1'h0);
    bus(0, 12'h930, 8'h80, 1'h1);
    chk(bw, 15'h1080);
    bus(0, 12'h933, 8'h00, 1'h0);
    bus(0, 12'h92c, 8'h00, 1'h0);
    bus(0, 12'h931, 8'h22, 1'h1);
    bus(1, 12'h931, 8'h22, 1'h0);
    chk(bw, 15'h2280);
    $display("loop test done");
  endtask
  task t_own;
    bus(1, 12'h934, 8'h01, 1'h1);
    bus(0, 12'h934, 8'h0f, 1'h0);
    @(posedge clk) wrOk <= 1'h1;
    bus(1, 12'h934, 8'h02, 1'h1);
    bus(0, 12'h934, 8'h02, 1'h0);
    bus(1, 12'h980, 8'h31, 1'h1);
    chk(own, 3'h0);
    bus(0, 12'h980, 8'hff, 1'h1);
    bus(1, 12'h980, 8'h31, 1'h0);
    chk(own, 3'h7);
    bus(0, 12'h980, 8'h00, 1'h1);
    @(posedge clk) loopHost <= 1'h1;
    bus(1, 12'h980, 8'h10, 1'h0);
    chk(own, 3'h2);
    $display("owner test done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    err_total++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'h1;
    t_loop();
    t_own();
    final_report();
  end
endmodule
